//--- design/bbo_unit.sv
// Branch, skip, I/O bit and shift unit with an AXI4-Lite register slave
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "bbo_cfg.svh"

// Operation
// - Skip next when register bit is zero
// - Skip next when register bit is one
// - Skip next when I/O bit is zero
// - Skip next when I/O bit is one
// - Generic status branch on chosen bit polarity
// - Equal and not-equal branch on zero
// - Carry branches, one or two cycles
// - Minus and plus branch on negative
// - Signed branches on negative XOR overflow
// - Half-carry branches on half-carry flag
// - T branches on T flag
// - Overflow branches on overflow flag
// - Interrupt branches on global enable flag
// - Force I/O bit, two cycles, no flags
// - Logical shifts fill zero, update four flags
// - Rotates pass through carry
// - Arithmetic right shift keeps sign bit
// - Nibble swap, no flags changed
// - Copy register bit into T only
// - Write T into register bit
module bbo_unit
  import bbo_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire bbo_axi_req_t axi_req,
  output bbo_axi_rsp_t      axi_rsp,
  output logic [15:0]       pc,
  output logic [7:0]        status_flags,
  output logic [7:0]        result,
  output logic              busy
);

  bbo_state_t st;
  bbo_state_t next_st;

  function automatic logic [31:0] wmerge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Condition of every branch as flag index and wanted level; the signed pair tests N xor V
  function automatic logic branch_cond(input bbo_op_t    op,
                                       input logic [2:0] sel,
                                       input logic [7:0] f);
    logic c;
    case (op)
      BBO_BR_STAT_HIGH: c = f[sel];
      BBO_BR_STAT_LOW:  c = !f[sel];
      BBO_BR_EQ:        c = f[`BBO_FLG_Z];
      BBO_BR_NE:        c = !f[`BBO_FLG_Z];
      BBO_BR_C_HIGH:    c = f[`BBO_FLG_C];
      BBO_BR_LOWER:     c = f[`BBO_FLG_C];
      BBO_BR_C_LOW:     c = !f[`BBO_FLG_C];
      BBO_BR_SAME_HI:   c = !f[`BBO_FLG_C];
      BBO_BR_NEG:       c = f[`BBO_FLG_N];
      BBO_BR_POS:       c = !f[`BBO_FLG_N];
      BBO_BR_SGE:       c = !(f[`BBO_FLG_N] ^ f[`BBO_FLG_V]);
      BBO_BR_SLT:       c = f[`BBO_FLG_N] ^ f[`BBO_FLG_V];
      BBO_BR_H_HIGH:    c = f[`BBO_FLG_H];
      BBO_BR_H_LOW:     c = !f[`BBO_FLG_H];
      BBO_BR_T_HIGH:    c = f[`BBO_FLG_T];
      BBO_BR_T_LOW:     c = !f[`BBO_FLG_T];
      BBO_BR_V_HIGH:    c = f[`BBO_FLG_V];
      BBO_BR_V_LOW:     c = !f[`BBO_FLG_V];
      BBO_BR_IRQ_EN:    c = f[`BBO_FLG_I];
      BBO_BR_IRQ_DIS:   c = !f[`BBO_FLG_I];
      default:          c = 1'b0;
    endcase
    return c;
  endfunction

  logic        wr_go;
  logic [31:0] wr_word;
  logic        go;
  logic        cond;
  logic [7:0]  shres;
  logic        shc;
  logic [15:0] koff_ext;
  logic [7:0]  bmask;

  always_comb begin
    next_st  = st;
    wr_go    = 1'b0;
    wr_word  = 32'h0000_0000;
    go       = 1'b0;
    cond     = 1'b0;
    shres    = 8'h00;
    shc      = 1'b0;
    koff_ext = 16'h0000;
    bmask    = 8'h00;

    // Execution countdown; the result was committed at issue
    case (st.fsm)
      BBO_IDLE: begin
        next_st.fsm = BBO_IDLE;
      end
      BBO_EXEC: begin
        if (st.cyc_left == `BBO_CYC_ONE) begin
          next_st.fsm  = BBO_IDLE;
          next_st.done = 1'b1;
        end else begin
          next_st.cyc_left = st.cyc_left - `BBO_CYC_ONE;
        end
      end
      default: begin
        next_st.fsm = BBO_IDLE;
      end
    endcase

    // Write channels are taken independently, in either order
    if (axi_req.awvalid && !st.aw_held && !st.bvalid) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr  = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st.w_held && !st.bvalid) begin
      next_st.w_held = 1'b1;
      next_st.wdata  = axi_req.wdata;
      next_st.wstrb  = axi_req.wstrb;
    end
    if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end

    // A response must be taken before either write channel opens again
    wr_go = st.aw_held && st.w_held && !st.bvalid;
    if (wr_go) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = `BBO_RESP_OKAY;
      case (st.awaddr)
        `BBO_OFF_CMD: begin
          // Commands arriving while busy are refused rather than queued
          if (st.fsm == BBO_EXEC) begin
            next_st.bresp = `BBO_RESP_SLVERR;
          end else begin
            wr_word          = wmerge(32'h0000_0000, st.wdata, st.wstrb);
            next_st.op       = bbo_op_t'(wr_word[`BBO_CMD_OP_LSB +: 6]);
            next_st.bit_sel  = wr_word[`BBO_CMD_BIT_LSB +: 3];
            next_st.stat_sel = wr_word[`BBO_CMD_S_LSB +: 3];
            next_st.two_word = wr_word[`BBO_CMD_TWO_WORD];
            go               = 1'b1;
          end
        end
        // Offset is stored raw and sign-extended only when a command issues
        `BBO_OFF_OPND: begin
          wr_word      = wmerge({9'h000, st.koff, 8'h00, st.opnd}, st.wdata, st.wstrb);
          next_st.opnd = wr_word[7:0];
          next_st.koff = wr_word[`BBO_OPND_K_LSB +: 7];
        end
        // PC and flags are locked while busy so the status word stays consistent
        `BBO_OFF_PC: begin
          if (st.fsm == BBO_EXEC) begin
            next_st.bresp = `BBO_RESP_SLVERR;
          end else begin
            wr_word    = wmerge({16'h0000, st.pc}, st.wdata, st.wstrb);
            next_st.pc = wr_word[15:0];
          end
        end
        `BBO_OFF_FLAGS: begin
          if (st.fsm == BBO_EXEC) begin
            next_st.bresp = `BBO_RESP_SLVERR;
          end else begin
            wr_word       = wmerge({24'h00_0000, st.flags}, st.wdata, st.wstrb);
            next_st.flags = wr_word[7:0];
          end
        end
        // Read-only words accept writes silently so a blind store never faults
        `BBO_OFF_RESULT, `BBO_OFF_STAT: begin
          next_st.bresp = `BBO_RESP_OKAY;
        end
        default: begin
          next_st.bresp = `BBO_RESP_SLVERR;
        end
      endcase
    end

    // Issue: PC, flags and result are updated at once, busy covers the cycles
    if (go) begin
      next_st.fsm    = BBO_EXEC;
      next_st.done   = 1'b0;
      next_st.taken  = 1'b0;
      next_st.io_we  = 1'b0;
      next_st.bad_op = 1'b0;
      next_st.cycles = `BBO_CYC_ONE;
      next_st.result = st.opnd;
      next_st.pc     = st.pc + `BBO_PC_ONE;
      // One mask serves both forced-bit forms
      bmask          = 8'h01 << next_st.bit_sel;
      koff_ext       = {{9{next_st.koff[6]}}, next_st.koff};
      case (next_st.op)
        BBO_SKIP_REG_LOW, BBO_SKIP_IO_LOW: begin
          cond = !st.opnd[next_st.bit_sel];
        end
        BBO_SKIP_REG_HIGH, BBO_SKIP_IO_HIGH: begin
          cond = st.opnd[next_st.bit_sel];
        end
        default: begin
          cond = branch_cond(next_st.op, next_st.stat_sel, st.flags);
        end
      endcase
      case (next_st.op)
        // Skipped word count comes from software; nothing is fetched here
        BBO_SKIP_REG_LOW, BBO_SKIP_REG_HIGH, BBO_SKIP_IO_LOW, BBO_SKIP_IO_HIGH: begin
          next_st.taken = cond;
          if (cond && next_st.two_word) begin
            next_st.cycles = `BBO_CYC_THREE;
            next_st.pc     = st.pc + `BBO_PC_THREE;
          end else if (cond) begin
            next_st.cycles = `BBO_CYC_TWO;
            next_st.pc     = st.pc + `BBO_PC_TWO;
          end
        end
        // Every branch shares one adder; the flag test only picks the target
        BBO_BR_STAT_HIGH, BBO_BR_STAT_LOW, BBO_BR_EQ, BBO_BR_NE, BBO_BR_C_HIGH,
        BBO_BR_C_LOW, BBO_BR_SAME_HI, BBO_BR_LOWER, BBO_BR_NEG, BBO_BR_POS,
        BBO_BR_SGE, BBO_BR_SLT, BBO_BR_H_HIGH, BBO_BR_H_LOW, BBO_BR_T_HIGH,
        BBO_BR_T_LOW, BBO_BR_V_HIGH, BBO_BR_V_LOW, BBO_BR_IRQ_EN, BBO_BR_IRQ_DIS: begin
          next_st.taken = cond;
          if (cond) begin
            next_st.cycles = `BBO_CYC_TWO;
            next_st.pc     = st.pc + `BBO_PC_ONE + koff_ext;
          end
        end
        BBO_IO_FORCE_ONE: begin
          next_st.result = st.opnd | bmask;
          next_st.cycles = `BBO_CYC_TWO;
          next_st.io_we  = 1'b1;
        end
        BBO_IO_FORCE_ZERO: begin
          next_st.result = st.opnd & ~bmask;
          next_st.cycles = `BBO_CYC_TWO;
          next_st.io_we  = 1'b1;
        end
        BBO_LSL, BBO_LSR, BBO_ROL, BBO_ROR, BBO_ASR: begin
          case (next_st.op)
            BBO_LSL: begin
              shres = {st.opnd[6:0], 1'b0};
              shc   = st.opnd[`BBO_MSB];
            end
            BBO_LSR: begin
              shres = {1'b0, st.opnd[7:1]};
              shc   = st.opnd[0];
            end
            BBO_ROL: begin
              shres = {st.opnd[6:0], st.flags[`BBO_FLG_C]};
              shc   = st.opnd[`BBO_MSB];
            end
            BBO_ROR: begin
              shres = {st.flags[`BBO_FLG_C], st.opnd[7:1]};
              shc   = st.opnd[0];
            end
            default: begin
              shres = {st.opnd[`BBO_MSB], st.opnd[7:1]};
              shc   = st.opnd[0];
            end
          endcase
          // Sign flag is left alone; only the four listed flags move
          // V is N xor C, so signed tests after a shift see the moved sign
          next_st.result              = shres;
          next_st.flags[`BBO_FLG_C]   = shc;
          next_st.flags[`BBO_FLG_Z]   = (shres == 8'h00);
          next_st.flags[`BBO_FLG_N]   = shres[`BBO_MSB];
          next_st.flags[`BBO_FLG_V]   = shres[`BBO_MSB] ^ shc;
        end
        BBO_SWAP: begin
          next_st.result = {st.opnd[3:0], st.opnd[7:4]};
        end
        BBO_BIT_TO_T: begin
          next_st.flags[`BBO_FLG_T] = st.opnd[next_st.bit_sel];
        end
        BBO_T_TO_BIT: begin
          next_st.result                   = st.opnd;
          next_st.result[next_st.bit_sel]  = st.flags[`BBO_FLG_T];
        end
        default: begin
          // Unknown codes still cost one cycle so software never hangs
          next_st.bad_op = 1'b1;
          next_st.pc     = st.pc;
        end
      endcase
      next_st.cyc_left = next_st.cycles;
    end

    // Read channel; one read outstanding, answered one cycle after address
    // Read data is registered so it cannot move while rvalid stands
    if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = `BBO_RESP_OKAY;
      case (axi_req.araddr)
        `BBO_OFF_CMD: begin
          next_st.rdata                         = 32'h0000_0000;
          next_st.rdata[`BBO_CMD_OP_LSB +: 6]   = st.op;
          next_st.rdata[`BBO_CMD_BIT_LSB +: 3]  = st.bit_sel;
          next_st.rdata[`BBO_CMD_S_LSB +: 3]    = st.stat_sel;
          next_st.rdata[`BBO_CMD_TWO_WORD]      = st.two_word;
        end
        `BBO_OFF_OPND: begin
          next_st.rdata                         = 32'h0000_0000;
          next_st.rdata[7:0]                    = st.opnd;
          next_st.rdata[`BBO_OPND_K_LSB +: 7]   = st.koff;
        end
        `BBO_OFF_PC:     next_st.rdata = {16'h0000, st.pc};
        `BBO_OFF_FLAGS:  next_st.rdata = {24'h00_0000, st.flags};
        `BBO_OFF_RESULT: next_st.rdata = {24'h00_0000, st.result};
        `BBO_OFF_STAT: begin
          next_st.rdata                         = 32'h0000_0000;
          next_st.rdata[`BBO_ST_BUSY]           = (st.fsm == BBO_EXEC);
          next_st.rdata[`BBO_ST_DONE]           = st.done;
          next_st.rdata[`BBO_ST_CYC_LSB +: 2]   = st.cycles;
          next_st.rdata[`BBO_ST_TAKEN]          = st.taken;
          next_st.rdata[`BBO_ST_IO_WE]          = st.io_we;
          next_st.rdata[`BBO_ST_BAD_OP]         = st.bad_op;
        end
        default: begin
          next_st.rdata = 32'h0000_0000;
          next_st.rresp = `BBO_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st          <= '0;
      st.fsm      <= BBO_IDLE;
      st.op       <= BBO_SKIP_REG_LOW;
      st.pc       <= `BBO_PC_RST;
      st.flags    <= `BBO_FLAGS_RST;
      st.bresp    <= `BBO_RESP_OKAY;
      st.rresp    <= `BBO_RESP_OKAY;
    end else begin
      st <= next_st;
    end
  end

  // Ready comes straight from flops, so no path runs from bus input to output
  always_comb begin
    axi_rsp.awready = !st.aw_held && !st.bvalid;
    axi_rsp.wready  = !st.w_held && !st.bvalid;
    axi_rsp.bvalid  = st.bvalid;
    axi_rsp.bresp   = st.bresp;
    axi_rsp.arready = !st.rvalid;
    axi_rsp.rvalid  = st.rvalid;
    axi_rsp.rdata   = st.rdata;
    axi_rsp.rresp   = st.rresp;
  end

  assign pc           = st.pc;
  assign status_flags = st.flags;
  assign result       = st.result;
  assign busy         = (st.fsm == BBO_EXEC);

endmodule

//--- inc/bbo_cfg.svh
// Constants for the branch, skip and bit operation unit
`ifndef BBO_CFG_SVH
`define BBO_CFG_SVH
`define BBO_AW          8
`define BBO_OFF_CMD     8'h00
`define BBO_OFF_OPND    8'h04
`define BBO_OFF_PC      8'h08
`define BBO_OFF_FLAGS   8'h0C
`define BBO_OFF_RESULT  8'h10
`define BBO_OFF_STAT    8'h14
`define BBO_FLG_C       0
`define BBO_FLG_Z       1
`define BBO_FLG_N       2
`define BBO_FLG_V       3
`define BBO_FLG_S       4
`define BBO_FLG_H       5
`define BBO_FLG_T       6
`define BBO_FLG_I       7
`define BBO_MSB         7
`define BBO_CMD_OP_LSB  0
`define BBO_CMD_BIT_LSB 8
`define BBO_CMD_S_LSB   12
`define BBO_CMD_TWO_WORD 16
`define BBO_OPND_K_LSB  16
`define BBO_ST_BUSY     0
`define BBO_ST_DONE     1
`define BBO_ST_CYC_LSB  4
`define BBO_ST_TAKEN    8
`define BBO_ST_IO_WE    9
`define BBO_ST_BAD_OP   10
`define BBO_CYC_ONE     2'h1
`define BBO_CYC_TWO     2'h2
`define BBO_CYC_THREE   2'h3
`define BBO_PC_ONE      16'h0001
`define BBO_PC_TWO      16'h0002
`define BBO_PC_THREE    16'h0003
`define BBO_PC_RST      16'h0000
`define BBO_FLAGS_RST   8'h00
`define BBO_RESP_OKAY   2'h0
`define BBO_RESP_SLVERR 2'h2
`endif

//--- inc/bbo_pkg.sv
// Types for the branch, skip and bit operation unit
package bbo_pkg;
  typedef enum logic [5:0] {
    BBO_SKIP_REG_LOW  = 6'h00, BBO_SKIP_REG_HIGH = 6'h01,
    BBO_SKIP_IO_LOW   = 6'h02, BBO_SKIP_IO_HIGH  = 6'h03,
    BBO_BR_STAT_HIGH  = 6'h04, BBO_BR_STAT_LOW   = 6'h05,
    BBO_BR_EQ         = 6'h06, BBO_BR_NE         = 6'h07,
    BBO_BR_C_HIGH     = 6'h08, BBO_BR_C_LOW      = 6'h09,
    BBO_BR_SAME_HI    = 6'h0A, BBO_BR_LOWER      = 6'h0B,
    BBO_BR_NEG        = 6'h0C, BBO_BR_POS        = 6'h0D,
    BBO_BR_SGE        = 6'h0E, BBO_BR_SLT        = 6'h0F,
    BBO_BR_H_HIGH     = 6'h10, BBO_BR_H_LOW      = 6'h11,
    BBO_BR_T_HIGH     = 6'h12, BBO_BR_T_LOW      = 6'h13,
    BBO_BR_V_HIGH     = 6'h14, BBO_BR_V_LOW      = 6'h15,
    BBO_BR_IRQ_EN     = 6'h16, BBO_BR_IRQ_DIS    = 6'h17,
    BBO_IO_FORCE_ONE  = 6'h18, BBO_IO_FORCE_ZERO = 6'h19,
    BBO_LSL           = 6'h1A, BBO_LSR           = 6'h1B,
    BBO_ROL           = 6'h1C, BBO_ROR           = 6'h1D,
    BBO_ASR           = 6'h1E, BBO_SWAP          = 6'h1F,
    BBO_BIT_TO_T      = 6'h20, BBO_T_TO_BIT      = 6'h21
  } bbo_op_t;

  typedef enum logic [0:0] {
    BBO_IDLE = 1'b0,
    BBO_EXEC = 1'b1
  } bbo_fsm_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } bbo_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bbo_axi_rsp_t;

  typedef struct packed {
    bbo_fsm_t    fsm;
    bbo_op_t     op;
    logic [2:0]  bit_sel;
    logic [2:0]  stat_sel;
    logic        two_word;
    logic [7:0]  opnd;
    logic [6:0]  koff;
    logic [15:0] pc;
    logic [7:0]  flags;
    logic [7:0]  result;
    logic [1:0]  cyc_left;
    logic [1:0]  cycles;
    logic        taken;
    logic        done;
    logic        io_we;
    logic        bad_op;
    logic        aw_held;
    logic [7:0]  awaddr;
    logic        w_held;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } bbo_state_t;
endpackage

//--- test/bbo_unit_monitor.sv
// Assertion checker for the branch, skip and bit operation unit
`timescale 1ns/1ps
`include "bbo_cfg.svh"
module bbo_unit_monitor
  import bbo_pkg::*;
(
  input wire logic         ref_clk,
  input wire logic         nrst,
  input wire bbo_axi_req_t axi_req,
  input wire bbo_axi_rsp_t axi_rsp,
  input wire logic [15:0]  pc,
  input wire logic [7:0]   status_flags,
  input wire logic [7:0]   result,
  input wire logic         busy
);
  logic [7:0]  aq;
  logic [31:0] wq;
  logic [31:0] oq;
  logic        bq;
  logic        iss;
  bbo_op_t     op;
  logic [7:0]  d;
  logic [2:0]  b;
  logic [15:0] kx;
  // Decode the commit edge from the bus alone, so no internal state is needed
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aq <= 8'h00;
      wq <= 32'h0000_0000;
      oq <= 32'h0000_0000;
      bq <= 1'b0;
    end else begin
      bq <= axi_rsp.bvalid;
      if (axi_req.awvalid && axi_rsp.awready) aq <= axi_req.awaddr;
      if (axi_req.wvalid && axi_rsp.wready) wq <= axi_req.wdata;
      if (axi_rsp.bvalid && !bq && aq == `BBO_OFF_OPND) oq <= wq;
    end
  end
  // A refused command answers with an error and must not count as issued
  assign iss = axi_rsp.bvalid && !bq && aq == `BBO_OFF_CMD
               && axi_rsp.bresp == `BBO_RESP_OKAY;
  assign op = bbo_op_t'(wq[5:0]);
  assign d = oq[7:0];
  assign b = wq[10:8];
  assign kx = {{9{oq[22]}}, oq[22:16]};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_lsl;
    iss && op == BBO_LSL |-> result == {d[6:0], 1'b0} && status_flags[0] == d[7];
  endproperty
  a_lsl: assert property (p_lsl) else $error("shift left wrong");
  property p_rol;
    iss && op == BBO_ROL |-> result == {d[6:0], $past(status_flags[0])};
  endproperty
  a_rol: assert property (p_rol) else $error("rotate left wrong");
  property p_swap;
    iss && op == BBO_SWAP |-> result == {d[3:0], d[7:4]} && $stable(status_flags);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_bst;
    iss && op == BBO_BIT_TO_T |->
      status_flags == {$past(status_flags[7]), d[b], $past(status_flags[5:0])};
  endproperty
  a_bst: assert property (p_bst) else $error("bit store wrong");
  property p_bld;
    iss && op == BBO_T_TO_BIT |-> result[b] == $past(status_flags[6]) && $stable(status_flags);
  endproperty
  a_bld: assert property (p_bld) else $error("bit load wrong");
  property p_io;
    iss && op inside {BBO_IO_FORCE_ONE, BBO_IO_FORCE_ZERO} |-> busy ##1 busy ##1 !busy;
  endproperty
  a_io: assert property (p_io) else $error("io force length wrong");
  property p_beq;
    iss && op == BBO_BR_EQ |->
      pc == $past(pc) + 16'h0001 + ($past(status_flags[1]) ? kx : 16'h0000);
  endproperty
  a_beq: assert property (p_beq) else $error("equal branch target wrong");
  property p_skip;
    iss && op == BBO_SKIP_REG_LOW && !d[b] |->
      pc == $past(pc) + (wq[16] ? 16'h0003 : 16'h0002);
  endproperty
  a_skip: assert property (p_skip) else $error("skip target wrong");
  property p_brc;
    iss && op == BBO_BR_C_HIGH && $past(status_flags[0]) |-> busy ##1 busy ##1 !busy;
  endproperty
  a_brc: assert property (p_brc) else $error("taken branch length wrong");
  c_lsl: cover property (iss && op == BBO_LSL);
  c_skip3: cover property (iss && op == BBO_SKIP_REG_HIGH && d[b] && wq[16]);
  c_beq: cover property (iss && op == BBO_BR_EQ && status_flags[1]);
endmodule
bind bbo_unit bbo_unit_monitor u_mon (.ref_clk(ref_clk), .nrst(nrst), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .pc(pc), .status_flags(status_flags), .result(result), .busy(busy));

//--- test/test_bbo_unit.sv
// Self-checking bench for the branch, skip and bit operation unit
`timescale 1ns/1ps
`include "bbo_cfg.svh"
module test_bbo_unit
  import bbo_pkg::*;
;
  logic         ref_clk;
  logic         nrst;
  bbo_axi_req_t req;
  bbo_axi_rsp_t rsp;
  logic [15:0]  pc;
  logic [7:0]   status_flags;
  logic [7:0]   result;
  logic         busy;
  int           num_errors;
  int           samples_checked;
  bbo_unit dut (.ref_clk(ref_clk), .nrst(nrst), .axi_req(req), .axi_rsp(rsp), .pc(pc),
    .status_flags(status_flags), .result(result), .busy(busy));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic end_sim();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // A wait that runs out is a failure in itself
  task automatic tmo(input int n);
    if (n >= 40) begin
      chk("wait_bound", 32'h0, 32'(n));
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= v;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    n = 0;
    r = 2'h3;
    do begin
      @(posedge ref_clk);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) begin
        req.bready <= 1'b0;
        r = rsp.bresp;
      end
    end while (r === 2'h3 && n < 40);
    tmo(n);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    n = 0;
    r = 2'h3;
    do begin
      @(posedge ref_clk);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) begin
        req.rready <= 1'b0;
        r = rsp.rresp;
        v = rsp.rdata;
      end
    end while (r === 2'h3 && n < 40);
    tmo(n);
  endtask
  // Load operand, pc and flags, issue, wait out busy and fetch the status word
  task automatic run(input logic [31:0] cmd, input logic [31:0] opnd, input logic [7:0] f,
      output logic [31:0] st);
    logic [1:0] r;
    int         n;
    wr(`BBO_OFF_OPND, opnd, r);
    wr(`BBO_OFF_PC, 32'h0000_1000, r);
    wr(`BBO_OFF_FLAGS, {24'h0, f}, r);
    wr(`BBO_OFF_CMD, cmd, r);
    n = 0;
    while (busy !== 1'b0 && n < 40) begin
      @(posedge ref_clk);
      n++;
    end
    tmo(n);
    rd(`BBO_OFF_STAT, st, r);
  endtask
  // Condition per op pair: tested value, then the level that makes it true
  function automatic logic cond(int i, logic [7:0] f, logic [2:0] s, logic [7:0] d,
      logic [2:0] b);
    logic [11:0] x;
    x = {f[7], f[3], f[6], f[5], f[2] ^ f[3], f[2], f[0], f[0], f[1], f[s], d[b], d[b]};
    return x[i / 2] == (i[0] ^ !(i / 2 inside {0, 1, 5, 7}));
  endfunction
  task automatic sc_misc();
    logic [31:0] v;
    logic [1:0]  r;
    chk("pc_rst", 32'h0, 32'(pc));
    chk("flags_rst", 32'h0, 32'(status_flags));
    rd(8'h18, v, r);
    chk("unmapped_resp", 32'(`BBO_RESP_SLVERR), 32'(r));
    wr(`BBO_OFF_PC, 32'h0000_ABCD, r);
    rd(`BBO_OFF_PC, v, r);
    chk("pc_read", 32'h0000_ABCD, v);
    run(32'h0000_003F, 32'h0, 8'h00, v);
    chk("bad_op", 32'h1, 32'(v[10]));
    chk("bad_op_pc", 32'h0000_1000, 32'(pc));
    chk("bad_op_cycles", 32'h1, 32'(v[5:4]));
    chk("bad_op_done", 32'h1, 32'(v[1]));
    chk("bad_op_busy", 32'h0, 32'(v[0]));
  endtask
  task automatic sc_cond();
    logic [31:0] st;
    logic [15:0] ep;
    logic [7:0]  f;
    logic [6:0]  k;
    logic [2:0]  b;
    logic [2:0]  s;
    logic        c;
    for (int i = 0; i < 24; i++) begin
      for (int j = 0; j < 4; j++) begin
        f = 8'(32'hAA55_FF00 >> (j * 8));
        b = 3'(j);
        s = 3'(j * 3);
        k = j[1] ? 7'h40 : 7'h3F;
        c = cond(i, f, s, 8'h5A, b);
        run(32'(i) | (32'(b) << 8) | (32'(s) << 12) | (32'(j % 2) << 16),
            {9'h0, k, 16'h005A}, f, st);
        if (i < 4) ep = 16'h1000 + (c ? 16'h0002 + 16'(j % 2) : 16'h0001);
        else ep = 16'h1001 + (c ? {{9{k[6]}}, k} : 16'h0000);
        chk("pc", 32'(ep), 32'(pc));
        chk("taken", 32'(c), 32'(st[8]));
        chk("cycles", 32'((i < 4 && c) ? 2 + j % 2 : 1 + c), 32'(st[5:4]));
        chk("flags", 32'(f), 32'(status_flags));
      end
    end
  endtask
  task automatic sc_bits();
    logic [31:0] st;
    logic [7:0]  d;
    logic [7:0]  f;
    logic [7:0]  r;
    logic [7:0]  nf;
    logic [2:0]  b;
    logic        c;
    for (int i = 24; i < 34; i++) begin
      for (int j = 0; j < 2; j++) begin
        d = j ? 8'h01 : 8'h81;
        f = j ? 8'hFF : 8'h00;
        b = j ? 3'h2 : 3'h7;
        run(32'(i) | (32'(b) << 8), {24'h0, d}, f, st);
        c = f[0];
        nf = f;
        r = d;
        case (i)
          24: r = d | (8'h01 << b);
          25: r = d & ~(8'h01 << b);
          26: {c, r} = {d, 1'b0};
          27: {r, c} = {1'b0, d};
          28: {c, r} = {d, f[0]};
          29: {r, c} = {f[0], d};
          30: {r, c} = {d[7], d};
          31: r = {d[3:0], d[7:4]};
          32: nf[6] = d[b];
          default: r[b] = f[6];
        endcase
        if (i inside {[26:30]}) nf[3:0] = {c ^ r[7], r[7], r == 8'h00, c};
        chk("result", 32'(r), 32'(result));
        chk("flags", 32'(nf), 32'(status_flags));
        chk("cycles", (i < 26) ? 32'h2 : 32'h1, 32'(st[5:4]));
        chk("io_we", 32'(i < 26), 32'(st[9]));
      end
    end
  endtask
  initial begin
    req = '0;
    nrst = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    sc_misc();
    sc_cond();
    sc_bits();
    end_sim();
  end
endmodule
